// ==== verilog/lpm_pkg.sv ====
// constants and types for the low-power mode controller
// Notes on behaviour
// [RULE1] lightest mode halts only the processor clock; peripheral clocks keep running
// [RULE2] any peripheral interrupt or event in lightest mode restarts processor clock
// [RULE3] intermediate mode stops all core-domain clocks, SRAM and registers retained
// [RULE4] entering intermediate mode disables PLL, internal RC and crystal oscillators
// [RULE5] intermediate mode powers core from main or low-power regulator, normal or under-drive
// [RULE6] regulator operation defaults to normal, not under-drive, unless configured
// [RULE7] intermediate mode exits on any enabled line: 16 pins, detector, clock, usb, ethernet
// [RULE8] deepest mode turns regulator off, core domain unpowered, PLL and oscillators off
// [RULE9] deepest mode loses SRAM and registers except backup domain and retained backup SRAM
// [RULE10] deepest mode exits on reset pin, watchdog reset or real-time-clock event
// [RULE11] a rising edge, not a level, on the wakeup pin exits deepest mode
// [RULE12] deepest mode unavailable when regulator bypassed and core powered externally
// [RULE13] at startup boot pins choose user flash, system memory or embedded SRAM
// [RULE14] board holds supervisor enable pin high where the package has that pin
// [RULE15] configured mode entered only on processor sleep request, mode from software bits
`default_nettype none
package lpm_pkg;
   localparam logic [11:0] LPM_CTRL_OFF = 12'h000;
   localparam logic [11:0] LPM_STAT_OFF = 12'h004;
   localparam logic [11:0] LPM_WKEN_OFF = 12'h008;
   localparam logic [11:0] LPM_BOOT_OFF = 12'h00C;
   // control register fields
   localparam int LPM_CTRL_DEEP_BIT = 0;
   localparam int LPM_CTRL_LPREG_BIT = 1;
   localparam int LPM_CTRL_UDRV_BIT = 2;
   localparam int LPM_CTRL_BKRET_BIT = 3;
   localparam int LPM_CTRL_STOP_BIT = 4;
   localparam logic [4:0] LPM_CTRL_RST = 5'h00;
   localparam logic [22:0] LPM_WKEN_RST = 23'h000000;
   localparam int LPM_EXT_LINES = 16;
   localparam int LPM_WAKE_LINES = 23;
   typedef enum logic [1:0] {LPM_BOOT_FLASH, LPM_BOOT_SYSMEM, LPM_BOOT_SRAM} lpm_boot_t;
   typedef enum {LPM_RUN, LPM_SLEEP, LPM_STOP, LPM_STANDBY} lpm_state_t;
endpackage
`default_nettype wire

// ==== verilog/lpm_sync.sv ====
// two-flop synchroniser for pin inputs
`default_nettype none
module lpm_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/lpm_boot.sv ====
// boot source capture after reset release
`default_nettype none
module lpm_boot
   import lpm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] boot_pins_s,
   output lpm_boot_t boot_sel,
   output logic boot_done
);
   logic [1:0] fill_r;
   // synchroniser restarts from zero with reset; latching earlier would always pick flash
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_r <= 2'h0;
         boot_sel <= LPM_BOOT_FLASH;
         boot_done <= 1'b0;
      end else begin
         fill_r <= {fill_r[0], 1'b1};
         if (fill_r[1] && !boot_done) begin
            boot_done <= 1'b1; // [RULE13]
            if (!boot_pins_s[0]) begin
               boot_sel <= LPM_BOOT_FLASH;
            end else if (!boot_pins_s[1]) begin
               boot_sel <= LPM_BOOT_SYSMEM;
            end else begin
               boot_sel <= LPM_BOOT_SRAM;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== verilog/lpm_ctrl.sv ====
// low-power mode controller top with apb registers
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`default_nettype none
module lpm_ctrl
   import lpm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_req,
   input wire logic periph_event,
   input wire logic [LPM_EXT_LINES-1:0] external_interrupt_lines,
   input wire logic supply_level_detector_output,
   input wire logic [3:0] rtc_events,
   input wire logic usb_wakeup,
   input wire logic eth_wakeup,
   input wire logic wakeup_pin,
   input wire logic external_reset_pin_n,
   input wire logic independent_watchdog_rst,
   input wire logic regulator_bypass,
   input wire logic [1:0] boot_pins,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic core_clk_en,
   output logic pll_en,
   output logic internal_rc_oscillator_en,
   output logic external_crystal_oscillator_en,
   output logic main_regulator_en,
   output logic low_power_regulator_en,
   output logic regulator_underdrive,
   output logic core_power_en,
   output logic backup_sram_retain,
   output logic core_state_lost,
   output logic wake_pulse,
   output lpm_boot_t boot_sel,
   output logic boot_done
);
   lpm_state_t state_r, state_nxt;
   logic [4:0] ctrl_r;
   logic [LPM_WAKE_LINES-1:0] wken_r;
   logic lost_r;
   logic [1:0] boot_pins_s;
   logic [LPM_WAKE_LINES-1:0] lines_s;
   logic [2:0] dw_s;
   logic wkp_prev_r;

   // all pin inputs except regulator_bypass pass two flops before use
   lpm_sync #(.W(2)) u_sync_boot (.pclk(pclk), .presetn(presetn), .d(boot_pins), .q(boot_pins_s));
   lpm_sync #(.W(LPM_WAKE_LINES)) u_sync_lines (
      .pclk(pclk),
      .presetn(presetn),
      .d({eth_wakeup, usb_wakeup, rtc_events, supply_level_detector_output, external_interrupt_lines}),
      .q(lines_s)
   );
   lpm_sync #(.W(3)) u_sync_dw (
      .pclk(pclk),
      .presetn(presetn),
      .d({wakeup_pin, ~external_reset_pin_n, independent_watchdog_rst}),
      .q(dw_s)
   );
   lpm_boot u_boot (
      .pclk(pclk),
      .presetn(presetn),
      .boot_pins_s(boot_pins_s),
      .boot_sel(boot_sel),
      .boot_done(boot_done)
   );

   // apb decode; zero wait states
   wire wr_en = psel && penable && pwrite;
   wire rd_setup = psel && !penable && !pwrite;
   wire hit_ctrl = paddr == LPM_CTRL_OFF;
   wire hit_stat = paddr == LPM_STAT_OFF;
   wire hit_wken = paddr == LPM_WKEN_OFF;
   wire hit_boot = paddr == LPM_BOOT_OFF;
   wire mapped = hit_ctrl || hit_stat || hit_wken || hit_boot;
   wire [31:0] rd_mux = hit_ctrl ? {27'h0000000, ctrl_r} :
                        hit_stat ? {29'h00000000, lost_r, state_r == LPM_RUN ? 2'h0 : 2'h1} :
                        hit_wken ? {9'h000, wken_r} :
                        hit_boot ? {30'h00000000, boot_sel} : 32'h00000000;

   // wake conditions
   wire wkp_rise = dw_s[2] && !wkp_prev_r; // [RULE11]
   wire stop_wake = |(lines_s & wken_r); // [RULE7]
   wire standby_wake = dw_s[1] || dw_s[0] || |lines_s[20:17] || wkp_rise; // [RULE10]
   wire deep_ok = !regulator_bypass; // [RULE12]

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         LPM_RUN: begin
            if (sleep_req) begin // [RULE15]
               if (ctrl_r[LPM_CTRL_DEEP_BIT] && deep_ok) begin
                  state_nxt = LPM_STANDBY;
               end else if (ctrl_r[LPM_CTRL_STOP_BIT]) begin
                  state_nxt = LPM_STOP;
               end else begin
                  state_nxt = LPM_SLEEP;
               end
            end
         end
         LPM_SLEEP: begin
            if (periph_event || stop_wake) begin // [RULE2]
               state_nxt = LPM_RUN;
            end
         end
         LPM_STOP: begin
            if (stop_wake) begin
               state_nxt = LPM_RUN;
            end
         end
         LPM_STANDBY: begin
            if (standby_wake) begin
               state_nxt = LPM_RUN;
            end
         end
      endcase
   end

   // outputs decoded from next state so they change with it
   wire in_sleep = state_nxt == LPM_SLEEP;
   wire in_stop = state_nxt == LPM_STOP;
   wire in_stby = state_nxt == LPM_STANDBY;
   wire lp_sel = ctrl_r[LPM_CTRL_LPREG_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= LPM_RUN;
         wkp_prev_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         wkp_prev_r <= dw_s[2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= LPM_CTRL_RST; // [RULE6]
         wken_r <= LPM_WKEN_RST;
      end else if (state_r == LPM_STANDBY && standby_wake) begin
         // core registers were unpowered; they come back at reset values
         ctrl_r <= LPM_CTRL_RST; // [RULE9]
         wken_r <= LPM_WKEN_RST; // [RULE9]
      end else if (wr_en && hit_ctrl) begin
         ctrl_r <= pwdata[4:0];
      end else if (wr_en && hit_wken) begin
         wken_r <= pwdata[LPM_WAKE_LINES-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lost_r <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // set wins over the read-clear of the status register
         if (state_r == LPM_STANDBY) begin
            lost_r <= 1'b1; // [RULE9]
         end else if (psel && penable && !pwrite && hit_stat) begin
            lost_r <= 1'b0;
         end
         prdata <= rd_setup ? rd_mux : 32'h00000000;
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         core_clk_en <= 1'b1;
         pll_en <= 1'b1;
         internal_rc_oscillator_en <= 1'b1;
         external_crystal_oscillator_en <= 1'b1;
         main_regulator_en <= 1'b1;
         low_power_regulator_en <= 1'b0;
         regulator_underdrive <= 1'b0;
         core_power_en <= 1'b1;
         backup_sram_retain <= 1'b0;
         core_state_lost <= 1'b0;
         wake_pulse <= 1'b0;
      end else begin
         cpu_clk_en <= !(in_sleep || in_stop || in_stby); // [RULE1]
         periph_clk_en <= !(in_stop || in_stby); // [RULE1]
         core_clk_en <= !(in_stop || in_stby); // [RULE3]
         pll_en <= !(in_stop || in_stby); // [RULE4] [RULE8]
         internal_rc_oscillator_en <= !(in_stop || in_stby); // [RULE4] [RULE8]
         external_crystal_oscillator_en <= !(in_stop || in_stby); // [RULE4] [RULE8]
         main_regulator_en <= !in_stby && !(in_stop && lp_sel); // [RULE5]
         low_power_regulator_en <= in_stop && lp_sel; // [RULE5]
         regulator_underdrive <= in_stop && ctrl_r[LPM_CTRL_UDRV_BIT]; // [RULE5] [RULE6]
         core_power_en <= !in_stby; // [RULE8]
         backup_sram_retain <= ctrl_r[LPM_CTRL_BKRET_BIT];
         core_state_lost <= in_stby; // [RULE9]
         wake_pulse <= state_r != LPM_RUN && state_nxt == LPM_RUN;
      end
   end

   property p_stop_clocks;
      @(posedge pclk) disable iff (!presetn) state_r == LPM_STOP |-> !core_clk_en && !pll_en;
   endproperty
   a_stop_clocks: assert property (p_stop_clocks) else $error("clocks running in stop"); // [RULE3]
   property p_sleep_periph;
      @(posedge pclk) disable iff (!presetn) state_r == LPM_SLEEP |-> !cpu_clk_en && periph_clk_en;
   endproperty
   a_sleep_periph: assert property (p_sleep_periph) else $error("sleep clock gating wrong"); // [RULE1]
   property p_sleep_wake;
      @(posedge pclk) disable iff (!presetn) state_r == LPM_SLEEP && periph_event |=> cpu_clk_en;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("sleep did not wake"); // [RULE2]
   property p_osc_off;
      @(posedge pclk) disable iff (!presetn)
         state_r == LPM_STANDBY |-> !internal_rc_oscillator_en && !external_crystal_oscillator_en && !core_power_en;
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("standby left power on"); // [RULE8]
   property p_bypass;
      @(posedge pclk) disable iff (!presetn) regulator_bypass && state_r == LPM_RUN |=> state_r != LPM_STANDBY;
   endproperty
   a_bypass: assert property (p_bypass) else $error("standby while bypassed"); // [RULE12]
   property p_no_req;
      @(posedge pclk) disable iff (!presetn) state_r == LPM_RUN && !sleep_req |=> state_r == LPM_RUN;
   endproperty
   a_no_req: assert property (p_no_req) else $error("entered mode without request"); // [RULE15]
   property p_stop_exit;
      @(posedge pclk) disable iff (!presetn) state_r == LPM_STOP && stop_wake |=> cpu_clk_en && core_clk_en;
   endproperty
   a_stop_exit: assert property (p_stop_exit) else $error("stop did not exit"); // [RULE7]
   property p_level_only;
      @(posedge pclk) disable iff (!presetn)
         state_r == LPM_STANDBY && $past(dw_s[2]) && dw_s[2] && lines_s[20:17] == 4'h0 && dw_s[1:0] == 2'h0
         |=> state_r == LPM_STANDBY;
   endproperty
   a_level_only: assert property (p_level_only) else $error("level woke standby"); // [RULE11]
   property p_reg_mode;
      @(posedge pclk) disable iff (!presetn) state_r == LPM_STOP |-> main_regulator_en != low_power_regulator_en;
   endproperty
   a_reg_mode: assert property (p_reg_mode) else $error("stop regulator selection wrong"); // [RULE5]

   // entry, exit and retention checks
   property p_stop_osc;
      @(posedge pclk) disable iff (!presetn)
         state_r == LPM_STOP |-> !internal_rc_oscillator_en && !external_crystal_oscillator_en && !pll_en;
   endproperty
   a_stop_osc: assert property (p_stop_osc) else $error("oscillators running in stop"); // [RULE4]
   property p_stop_keep;
      @(posedge pclk) disable iff (!presetn) state_r == LPM_STOP |-> core_power_en && !core_state_lost;
   endproperty
   a_stop_keep: assert property (p_stop_keep) else $error("stop lost core contents"); // [RULE3]
   property p_stby_reg;
      @(posedge pclk) disable iff (!presetn)
         state_r == LPM_STANDBY |-> !pll_en && !main_regulator_en && !low_power_regulator_en;
   endproperty
   a_stby_reg: assert property (p_stby_reg) else $error("regulator or pll on in standby"); // [RULE8]
   property p_udrv_default;
      @(posedge pclk) disable iff (!presetn)
         state_r == LPM_STOP && !$past(ctrl_r[LPM_CTRL_UDRV_BIT]) |-> !regulator_underdrive;
   endproperty
   a_udrv_default: assert property (p_udrv_default) else $error("under-drive without configuration"); // [RULE6]
   property p_udrv_run;
      @(posedge pclk) disable iff (!presetn) state_r != LPM_STOP |-> !regulator_underdrive;
   endproperty
   a_udrv_run: assert property (p_udrv_run) else $error("under-drive outside stop"); // [RULE6]
   property p_stby_lost;
      @(posedge pclk) disable iff (!presetn) state_r == LPM_STANDBY |-> core_state_lost;
   endproperty
   a_stby_lost: assert property (p_stby_lost) else $error("standby not marked as lost"); // [RULE9]
   property p_stby_clear;
      @(posedge pclk) disable iff (!presetn)
         state_r == LPM_STANDBY && standby_wake |=> ctrl_r == LPM_CTRL_RST && wken_r == LPM_WKEN_RST;
   endproperty
   a_stby_clear: assert property (p_stby_clear) else $error("registers kept over standby"); // [RULE9]
   property p_stby_exit;
      @(posedge pclk) disable iff (!presetn)
         state_r == LPM_STANDBY && standby_wake |=> state_r == LPM_RUN && core_power_en;
   endproperty
   a_stby_exit: assert property (p_stby_exit) else $error("standby did not exit"); // [RULE10]
   property p_pin_rise;
      @(posedge pclk) disable iff (!presetn)
         state_r == LPM_STANDBY && dw_s[2] && !$past(dw_s[2]) |=> state_r == LPM_RUN;
   endproperty
   a_pin_rise: assert property (p_pin_rise) else $error("wakeup pin edge ignored"); // [RULE11]
   property p_sleep_line;
      @(posedge pclk) disable iff (!presetn) state_r == LPM_SLEEP && stop_wake |=> cpu_clk_en;
   endproperty
   a_sleep_line: assert property (p_sleep_line) else $error("sleep ignored an event"); // [RULE2]
   property p_stop_hold;
      @(posedge pclk) disable iff (!presetn) state_r == LPM_STOP && !stop_wake |=> state_r == LPM_STOP;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop left without enabled line"); // [RULE7]
   property p_enter_sleep;
      @(posedge pclk) disable iff (!presetn)
         state_r == LPM_RUN && sleep_req && !ctrl_r[LPM_CTRL_DEEP_BIT] && !ctrl_r[LPM_CTRL_STOP_BIT] |=> state_r == LPM_SLEEP;
   endproperty
   a_enter_sleep: assert property (p_enter_sleep) else $error("sleep not entered"); // [RULE1]
   property p_enter_stop;
      @(posedge pclk) disable iff (!presetn)
         state_r == LPM_RUN && sleep_req && !ctrl_r[LPM_CTRL_DEEP_BIT] && ctrl_r[LPM_CTRL_STOP_BIT] |=> state_r == LPM_STOP;
   endproperty
   a_enter_stop: assert property (p_enter_stop) else $error("stop not entered"); // [RULE15]
   property p_enter_stby;
      @(posedge pclk) disable iff (!presetn)
         state_r == LPM_RUN && sleep_req && ctrl_r[LPM_CTRL_DEEP_BIT] && !regulator_bypass |=> state_r == LPM_STANDBY;
   endproperty
   a_enter_stby: assert property (p_enter_stby) else $error("standby not entered"); // [RULE8]
   property p_boot_hold;
      @(posedge pclk) disable iff (!presetn) boot_done |=> boot_done && $stable(boot_sel);
   endproperty
   a_boot_hold: assert property (p_boot_hold) else $error("boot choice changed"); // [RULE13]
endmodule
`default_nettype wire

// ==== testbench/lpm_cpu_model.sv ====
// processor core model: raises the sleep request and holds it until its clock is gated
`default_nettype none
module lpm_cpu_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic cpu_clk_en,
   output logic sleep_req
);
   timeunit 1ns;
   timeprecision 1ns;
   // dropping early would lose the request, holding it longer would re-enter after wake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sleep_req <= 1'b0;
      else if (go)
         sleep_req <= 1'b1;
      else if (!cpu_clk_en)
         sleep_req <= 1'b0;
   end
endmodule
`default_nettype wire

// ==== testbench/low_power_mode_controller_bench.sv ====
// self-checking bench for the low-power mode controller
`default_nettype none
module low_power_mode_controller_bench
   import lpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic sleep_go = 1'b0, periph_event = 1'b0, wakeup_pin = 1'b0, external_reset_pin_n = 1'b1;
   logic independent_watchdog_rst = 1'b0, regulator_bypass = 1'b0, er;
   logic supervisor_enable_pin = 1'b1; // board keeps the supply supervisor on
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic [22:0] wk = 23'h000000;
   logic [1:0] boot_pins = 2'h0;
   logic [4:0] c;
   logic pready, pslverr, cpu_clk_en, periph_clk_en, core_clk_en, pll_en, boot_done, sleep_req;
   logic internal_rc_oscillator_en, external_crystal_oscillator_en, main_regulator_en;
   logic low_power_regulator_en, regulator_underdrive, core_power_en, backup_sram_retain;
   logic core_state_lost, wake_pulse;
   lpm_boot_t boot_sel;
   int num_errors = 0, num_checks = 0, k, ln;

   lpm_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleep_req(sleep_req), .periph_event(periph_event), .external_interrupt_lines(wk[15:0]),
      .supply_level_detector_output(wk[16]), .rtc_events(wk[20:17]), .usb_wakeup(wk[21]), .eth_wakeup(wk[22]),
      .wakeup_pin(wakeup_pin), .external_reset_pin_n(external_reset_pin_n),
      .independent_watchdog_rst(independent_watchdog_rst), .regulator_bypass(regulator_bypass),
      .boot_pins(boot_pins), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .core_clk_en(core_clk_en),
      .pll_en(pll_en), .internal_rc_oscillator_en(internal_rc_oscillator_en),
      .external_crystal_oscillator_en(external_crystal_oscillator_en), .main_regulator_en(main_regulator_en),
      .low_power_regulator_en(low_power_regulator_en), .regulator_underdrive(regulator_underdrive),
      .core_power_en(core_power_en), .backup_sram_retain(backup_sram_retain), .core_state_lost(core_state_lost),
      .wake_pulse(wake_pulse), .boot_sel(boot_sel), .boot_done(boot_done));
   lpm_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .go(sleep_go), .cpu_clk_en(cpu_clk_en),
      .sleep_req(sleep_req));

   initial forever #5 pclk = ~pclk;

   task automatic complete_run;
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      #100000;
      num_errors++;
      complete_run();
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // model: 0 run, 1 sleep, 2 stop, 3 standby; vector is cpu..xtal, mr, lpr, udrv, power, lost
   task automatic expect_mode(input int m, input logic [4:0] cf);
      logic [10:0] e;
      e = (m == 0) ? 11'h7F2 : (m == 1) ? 11'h3F2 : (m == 2) ? {6'h00, !cf[1], cf[1], cf[2], 2'h2} : 11'h001;
      chk({21'h0, cpu_clk_en, periph_clk_en, core_clk_en, pll_en, internal_rc_oscillator_en,
         external_crystal_oscillator_en, main_regulator_en, low_power_regulator_en,
         regulator_underdrive, core_power_en, core_state_lost}, {21'h0, e}, "gating");
      if (m == 3)
         chk({31'h0, backup_sram_retain}, {31'h0, cf[3]}, "retain");
   endtask

   task automatic enter(input logic [4:0] cf, input int m);
      apb(1'b1, LPM_CTRL_OFF, {27'h0, cf});
      @(posedge pclk);
      sleep_go <= 1'b1;
      @(posedge pclk);
      sleep_go <= 1'b0;
      repeat (2) @(posedge pclk);
      #1 expect_mode(m, cf);
   endtask

   // pulse comes in the same cycle as the restored clock
   task automatic wake;
      bit seen;
      int i;
      seen = 1'b0;
      #1;
      for (i = 0; i < 12; i++) begin
         if (wake_pulse === 1'b1)
            seen = 1'b1;
         if (cpu_clk_en === 1'b1 && seen)
            break;
         @(posedge pclk);
         #1;
      end
      chk({31'h0, seen}, 32'h1, "wake pulse");
      expect_mode(0, 5'h00);
      // hand back on an edge so callers drive pins by non-blocking assignment
      @(posedge pclk);
   endtask

   initial begin
      void'($urandom(47365));
      boot_pins <= 2'($urandom);
      repeat (16) @(posedge pclk);
      presetn <= supervisor_enable_pin;
      // boot choice waits for the pin synchroniser to fill
      repeat (3) @(posedge pclk);
      #1 chk({29'h0, boot_done, boot_sel}, !boot_pins[0] ? 32'h4 : boot_pins[1] ? 32'h6 : 32'h5, "boot");
      expect_mode(0, 5'h00);
      apb(1'b0, LPM_BOOT_OFF, 32'h0);
      chk(rd, !boot_pins[0] ? 32'h0 : boot_pins[1] ? 32'h2 : 32'h1, "boot register");
      apb(1'b0, LPM_CTRL_OFF, 32'h0);
      chk(rd, 32'h0, "ctrl reset");
      apb(1'b0, LPM_WKEN_OFF, 32'h0);
      chk(rd, 32'h0, "wken reset");
      c = 5'($urandom);
      apb(1'b1, LPM_CTRL_OFF, {27'($urandom), c});
      apb(1'b0, LPM_CTRL_OFF, 32'h0);
      chk(rd, {27'h0, c}, "ctrl");
      apb(1'b0, 12'h010, 32'h0);
      chk({rd[30:0], er}, 32'h1, "unmapped");
      // sleep: peripheral event restarts the processor clock
      enter(5'h00, 1);
      @(posedge pclk);
      periph_event <= 1'b1;
      @(posedge pclk);
      periph_event <= 1'b0;
      wake();
      // stop: every regulator setting, disabled line ignored, enabled line wakes
      for (k = 0; k < 4; k++) begin
         ln = $urandom_range(22);
         apb(1'b1, LPM_WKEN_OFF, 32'h1 << ln);
         c = {2'h2, k[1:0], 1'b0};
         enter(c, 2);
         @(posedge pclk);
         wk <= 23'h1 << ((ln + 1) % 23);
         repeat (6) @(posedge pclk);
         #1 expect_mode(2, c);
         @(posedge pclk);
         wk <= 23'h1 << ln;
         wake();
         wk <= 23'h0;
      end
      // standby: each exit source; wakeup pin needs an edge, a standing level must not wake
      for (k = 0; k < 4; k++) begin
         c = 5'h01 | 5'($urandom_range(1) << 3);
         wakeup_pin <= (k == 3);
         enter(c, 3);
         if (k == 3) begin
            repeat (6) @(posedge pclk);
            #1 expect_mode(3, c);
            @(posedge pclk);
            wakeup_pin <= 1'b0;
            repeat (4) @(posedge pclk);
         end
         @(posedge pclk);
         case (k)
            0: external_reset_pin_n <= 1'b0;
            1: independent_watchdog_rst <= 1'b1;
            2: wk <= 23'h1 << (17 + $urandom_range(3));
            default: wakeup_pin <= 1'b1;
         endcase
         wake();
         external_reset_pin_n <= 1'b1;
         independent_watchdog_rst <= 1'b0;
         wk <= 23'h0;
         wakeup_pin <= 1'b0;
         apb(1'b0, LPM_CTRL_OFF, 32'h0);
         chk(rd, 32'h0, "ctrl after standby");
         apb(1'b0, LPM_STAT_OFF, 32'h0);
         chk({29'h0, rd[2:0]}, 32'h4, "state lost");
      end
      // bypassed regulator: standby falls back to stop, then to sleep
      regulator_bypass <= 1'b1;
      apb(1'b1, LPM_WKEN_OFF, 32'h1);
      enter(5'h11, 2);
      @(posedge pclk);
      wk <= 23'h1;
      wake();
      wk <= 23'h0;
      enter(5'h01, 1);
      @(posedge pclk);
      periph_event <= 1'b1;
      @(posedge pclk);
      periph_event <= 1'b0;
      wake();
      apb(1'b0, LPM_STAT_OFF, 32'h0);
      chk(rd, 32'h0, "state lost cleared by read");
      complete_run();
   end
endmodule
`default_nettype wire
